// ==== logic/command_decoder.sv ====
// Opcode decoder for bus transactions, issuing one-cycle command strobes
`timescale 1ns/1ps
`default_nettype none
module command_decoder (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire touch_pkg::bus_xact_s xact,
  output var  touch_pkg::cmd_s      cmd,
  output var  touch_pkg::rd_sel_e   rd_sel,
  output var  logic                 fetch
);
  typedef enum logic [3:0] {
    DEC_IDLE   = 4'b0001,
    DEC_OPCODE = 4'b0010,
    DEC_DATA   = 4'b0100,
    DEC_DONE   = 4'b1000
  } dec_e;

  dec_e       state;
  logic [7:0] opcode;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state <= DEC_IDLE;
    else if (xact.start)
      state <= xact.rw ? DEC_DONE : DEC_OPCODE;
    else
      case (state)
        DEC_OPCODE: if (xact.wr_valid) state <= (is_write_op(xact.wr_byte) ? DEC_DATA : DEC_DONE);
        DEC_DATA:   if (xact.wr_valid) state <= DEC_DONE;
        DEC_IDLE:   state <= DEC_IDLE;
        DEC_DONE:   state <= DEC_DONE;
        default:    state <= DEC_IDLE;
      endcase
  end

  function automatic logic is_write_op(input logic [7:0] op);
    is_write_op = op == touch_pkg::OP_WR_CONFIG || op == touch_pkg::OP_WR_CLOCK
               || op == touch_pkg::OP_WR_MASK;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      opcode <= 8'hFF;
    else if (state == DEC_OPCODE && xact.wr_valid && !xact.start)
      opcode <= xact.wr_byte;
  end

  // Unknown opcodes fall through every compare and raise no strobe
  always_ff @(posedge clk_sys)
  begin
    cmd <= '0;
    if (!reset && !xact.start && xact.wr_valid)
    begin
      if (state == DEC_OPCODE)
      begin
        cmd.reinit    <= xact.wr_byte == touch_pkg::OP_REINIT;
        cmd.int_clear <= xact.wr_byte == touch_pkg::OP_INT_CLEAR;
        cmd.sleep     <= xact.wr_byte == touch_pkg::OP_SLEEP;
        cmd.wake      <= xact.wr_byte == touch_pkg::OP_WAKE;
        cmd.bus_int   <= xact.wr_byte == touch_pkg::OP_BUS_INT;
      end
      else if (state == DEC_DATA)
      begin
        cmd.wr_config <= opcode == touch_pkg::OP_WR_CONFIG;
        cmd.wr_clock  <= opcode == touch_pkg::OP_WR_CLOCK;
        cmd.wr_mask   <= opcode == touch_pkg::OP_WR_MASK;
        cmd.data      <= xact.wr_byte;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || xact.start)
      rd_sel <= touch_pkg::RD_STATE;
    else if (state == DEC_OPCODE && xact.wr_valid)
      case (xact.wr_byte)
        touch_pkg::OP_RD_CONFIG: rd_sel <= touch_pkg::RD_CONFIG;
        touch_pkg::OP_RD_CLOCK:  rd_sel <= touch_pkg::RD_CLOCK;
        touch_pkg::OP_RD_MASK:   rd_sel <= touch_pkg::RD_MASK;
        default:                 rd_sel <= touch_pkg::RD_STATE;
      endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      fetch <= 1'b0;
    else if (xact.start)
      fetch <= xact.rw;
  end

  chk_write_config: assert property (@(posedge clk_sys) disable iff (reset)
    state == DEC_DATA && opcode == touch_pkg::OP_WR_CONFIG && xact.wr_valid && !xact.start
    |=> cmd.wr_config && cmd.data == $past(xact.wr_byte))
    else $error("write-config data byte not forwarded");
  chk_unknown_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    state == DEC_OPCODE && xact.wr_valid && !xact.start && xact.wr_byte == 8'h01
    |=> cmd == '0 ##1 !cmd.wr_config && !cmd.wr_clock && !cmd.wr_mask)
    else $error("undefined opcode raised a command");
  chk_sleep_decode: assert property (@(posedge clk_sys) disable iff (reset)
    cmd.sleep |-> $past(xact.wr_byte) == touch_pkg::OP_SLEEP && !cmd.wake)
    else $error("sleep strobe without sleep opcode");
endmodule
`default_nettype wire

// ==== logic/pulse_run_counter.sv ====
// Per-channel counter of consecutive same-direction pulses and detect flag
`timescale 1ns/1ps
`default_nettype none
module pulse_run_counter (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic up,
  input  wire logic down,
  output var  logic detect
);
  logic [touch_pkg::RUN_W-1:0] run;
  logic                        last_up;
  logic [touch_pkg::RUN_W-1:0] next_run;

  always_comb
  begin
    if (up != last_up)
      next_run = 7'h01;
    else if (run != 7'h7F)
      next_run = run + 7'h01;
    else
      next_run = run;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      run     <= 7'h00;
      last_up <= 1'b0;
    end
    else if (up || down)
    begin
      run     <= next_run;
      last_up <= up;
    end
  end

  // A long down run switches the output off again
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      detect <= 1'b0;
    else if (up && next_run == touch_pkg::DETECT_RUN)
      detect <= 1'b1;
    else if (down && next_run == touch_pkg::RELEASE_RUN)
      detect <= 1'b0;
  end

  chk_detect_run: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(detect) |-> last_up && run == touch_pkg::DETECT_RUN)
    else $error("detect rose without 64 consecutive up pulses");
  chk_run_restart: assert property (@(posedge clk_sys) disable iff (reset)
    (up && !last_up) || (down && last_up) |=> run == 7'h01)
    else $error("run not restarted on direction change");
endmodule
`default_nettype wire

// ==== logic/touch_core.sv ====
// Digital core: channel sequencing, pulse arbitration, sensor state, sleep and commands
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Channels sampled in turn; reference timer triggered at each sampling instant.
// - Reference tripping first gives an up pulse, channel first gives down.
// - Per-channel counter counts same-direction pulses, restarted at 1 on direction change.
// - Detect output activates only after 64 consecutive up pulses.
// - Detect states captured into sensor state; any change raises interrupt pin except in bus interrupt mode.
// - Config, clock and mask written only by own commands; single commands other than reinit leave them.
// - Opcodes 00h reinit, 05h sleep, 06h wake, none with data.
// - Opcode 03h deactivates the interrupt pin indication.
// - Opcode 30h writes configuration byte; 33h returns it.
// - Opcode 35h writes clock setting byte; 36h returns it.
// - Opcode 39h writes mask byte; 3Ah returns it.
// - Opcode 3Ch enters bus interrupt mode, no data byte.
// - Read bit set in address byte means a sensor state fetch.
// - State fetch returns sensor state and releases the interrupt pin.
// - Repeated read bytes return sensor state; cascaded chips alternate bytes.
// - Reset only at power-on or by the reinit command.
// - Reinit restores channels, registers, ends bus interrupt mode.
// - Sleep powers down analog blocks, oscillator and regulator; the core only clears analog_en and has no oscillator or regulator control.
// - Asleep, registers are kept and commands still answered.
// - Leaving sleep runs the start-up phase with fast reservoir charging.
// - Sleep entered by command or pin high; left by wake or pin low.
// - Command sleep and pin sleep tracked separately, each ends its own way.
module touch_core (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 sleep_pin,
  input  wire logic                 ref_tripped,
  input  wire logic [7:0]           chan_tripped,
  input  wire touch_pkg::bus_xact_s xact,
  output var  logic [7:0]           rd_data,
  output var  logic                 rd_own,
  output var  logic                 int_n,
  output var  logic                 bus_int_mode,
  output var  logic                 ref_trigger,
  output var  logic [7:0]           chan_sel,
  output var  logic [7:0]           up_pulse,
  output var  logic [7:0]           down_pulse,
  output var  logic                 analog_en,
  output var  logic                 fast_start,
  output var  logic [7:0]           config_reg,
  output var  logic [7:0]           clock_setting_reg,
  output var  logic [7:0]           mask_reg,
  output var  logic [7:0]           sensor_state_reg
);
  typedef enum logic [3:0] {
    ST_SLEEP   = 4'b0001,
    ST_STARTUP = 4'b0010,
    ST_SAMPLE  = 4'b0100,
    ST_GAP     = 4'b1000
  } seq_e;

  touch_pkg::cmd_s    cmd;
  touch_pkg::rd_sel_e rd_sel;
  logic               fetch;
  logic               rst_int;
  seq_e               state;
  logic [2:0]         idx;
  logic [9:0]         timer;
  logic [7:0]         detect;
  logic [7:0]         next_state;
  logic               sw_sleep;
  logic               asleep;
  logic               int_pending;
  logic               clear_int;

  // Three-stage synchronisers; a level counts once stages two and three agree
  // Bits 7..0 channels, bit 8 the reference, bit 9 the sleep pin
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic [9:0] sync3;
  logic [9:0] filt;
  logic [9:0] raw_in;

  assign raw_in = {sleep_pin, ref_tripped, chan_tripped};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        sync1[gi] <= raw_in[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        if (reset)
          filt[gi] <= 1'b0;
        else if (sync2[gi] == sync3[gi])
          filt[gi] <= sync3[gi];
      end
    end
  endgenerate

  // No reset pin: power-on reset and the reinit command are the only sources
  assign rst_int = reset || cmd.reinit;

  command_decoder u_decoder (
    .clk_sys (clk_sys),
    .reset   (reset),
    .xact    (xact),
    .cmd     (cmd),
    .rd_sel  (rd_sel),
    .fetch   (fetch)
  );

  generate
    for (gi = 0; gi < touch_pkg::CHANNELS; gi++)
    begin : g_chan
      pulse_run_counter u_run (
        .clk_sys (clk_sys),
        .reset   (rst_int),
        .up      (up_pulse[gi]),
        .down    (down_pulse[gi]),
        .detect  (detect[gi])
      );
    end
  endgenerate

  // Pin sleep is the filtered level itself, so only the pin can end it
  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
      sw_sleep <= 1'b0;
    else if (cmd.sleep)
      sw_sleep <= 1'b1;
    else if (cmd.wake)
      sw_sleep <= 1'b0;
  end

  assign asleep = sw_sleep || filt[9];

  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
    begin
      state       <= ST_STARTUP;
      idx         <= 3'h0;
      timer       <= 10'h000;
      ref_trigger <= 1'b0;
      chan_sel    <= 8'h00;
      up_pulse    <= 8'h00;
      down_pulse  <= 8'h00;
      analog_en   <= 1'b1;
      fast_start  <= 1'b1;
    end
    else
    begin
      up_pulse   <= 8'h00;
      down_pulse <= 8'h00;
      if (asleep)
      begin
        state       <= ST_SLEEP;
        analog_en   <= 1'b0;
        fast_start  <= 1'b0;
        ref_trigger <= 1'b0;
        chan_sel    <= 8'h00;
      end
      else
        case (state)
          ST_SLEEP:
          begin
            state      <= ST_STARTUP;
            analog_en  <= 1'b1;
            fast_start <= 1'b1;
            timer      <= 10'h000;
            idx        <= 3'h0;
          end
          ST_STARTUP:
            if (timer == 10'(touch_pkg::FAST_START_CYCLES - 1))
            begin
              state       <= ST_SAMPLE;
              fast_start  <= 1'b0;
              timer       <= 10'h000;
              ref_trigger <= 1'b1;
              chan_sel    <= 8'h01 << idx;
            end
            else
              timer <= timer + 10'h001;
          ST_SAMPLE:
          begin
            // Reference wins a tie: both tripping together counts as up
            if (filt[idx] || filt[8] || timer == 10'(touch_pkg::SAMPLE_CYCLES - 1))
            begin
              if (filt[8])
                up_pulse[idx] <= 1'b1;
              else if (filt[idx])
                down_pulse[idx] <= 1'b1;
              state       <= ST_GAP;
              timer       <= 10'h000;
              ref_trigger <= 1'b0;
              chan_sel    <= 8'h00;
            end
            else
              timer <= timer + 10'h001;
          end
          ST_GAP:
            // Sampling rate follows the clock setting byte
            if (timer[7:0] == touch_pkg::GAP_BASE + {3'h0, clock_setting_reg[4:0]})
            begin
              state       <= ST_SAMPLE;
              timer       <= 10'h000;
              idx         <= idx + 3'h1;
              ref_trigger <= 1'b1;
              chan_sel    <= 8'h01 << (idx + 3'h1);
            end
            else
              timer <= timer + 10'h001;
          default:
            state <= ST_STARTUP;
        endcase
    end
  end

  // Registers keep their contents through sleep; only reset or reinit restores them
  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
    begin
      config_reg        <= touch_pkg::CONFIG_RESET;
      clock_setting_reg <= touch_pkg::CLOCK_RESET;
      mask_reg          <= touch_pkg::MASK_RESET;
      bus_int_mode      <= 1'b0;
    end
    else
    begin
      if (cmd.wr_config)
        config_reg <= cmd.data;
      if (cmd.wr_clock)
        clock_setting_reg <= cmd.data;
      if (cmd.wr_mask)
        mask_reg <= cmd.data;
      if (cmd.bus_int)
        bus_int_mode <= 1'b1;
    end
  end

  assign next_state = detect & mask_reg;
  assign clear_int  = cmd.int_clear || (fetch && xact.rd_req);

  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
    begin
      sensor_state_reg <= touch_pkg::STATE_RESET;
      int_pending      <= 1'b0;
      int_n            <= 1'b1;
    end
    else
    begin
      sensor_state_reg <= next_state;
      // A new change wins over a clear in the same cycle
      if (next_state != sensor_state_reg)
        int_pending <= 1'b1;
      else if (clear_int)
        int_pending <= 1'b0;
      int_n <= !((int_pending && !clear_int) || next_state != sensor_state_reg) || bus_int_mode;
    end
  end

  // Read bytes: cascaded chips take turns, primary on even bytes
  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
    begin
      rd_data <= 8'h00;
      rd_own  <= 1'b1;
    end
    else if (xact.start)
      rd_own <= config_reg[touch_pkg::OPM_LSB +: 2] != touch_pkg::OPM_SECONDARY;
    else if (xact.rd_req)
    begin
      if (fetch)
        rd_data <= sensor_state_reg;
      else
        case (rd_sel)
          touch_pkg::RD_CONFIG: rd_data <= config_reg;
          touch_pkg::RD_CLOCK:  rd_data <= clock_setting_reg;
          touch_pkg::RD_MASK:   rd_data <= mask_reg;
          default:              rd_data <= sensor_state_reg;
        endcase
      if (config_reg[touch_pkg::OPM_LSB +: 2] == touch_pkg::OPM_PRIMARY
          || config_reg[touch_pkg::OPM_LSB +: 2] == touch_pkg::OPM_SECONDARY)
        rd_own <= !rd_own;
    end
  end

  chk_reinit_defaults: assert property (@(posedge clk_sys) disable iff (reset)
    cmd.reinit |=> config_reg == touch_pkg::CONFIG_RESET && mask_reg == touch_pkg::MASK_RESET
                   && !bus_int_mode && !sw_sleep)
    else $error("reinit left state off its defaults");
  chk_sleep_power: assert property (@(posedge clk_sys) disable iff (reset)
    asleep && !cmd.reinit |=> !analog_en && !ref_trigger)
    else $error("analog active while asleep");
  chk_wake_startup: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(analog_en) |-> fast_start ##1 state == ST_STARTUP)
    else $error("wake without start-up phase");
  chk_pin_wake: assert property (@(posedge clk_sys) disable iff (reset)
    sw_sleep && !cmd.wake && !cmd.reinit |=> sw_sleep)
    else $error("command sleep ended without wake");
  chk_int_raise: assert property (@(posedge clk_sys) disable iff (reset)
    next_state != sensor_state_reg && !bus_int_mode && !cmd.reinit |=> !int_n)
    else $error("state change gave no interrupt");
  chk_int_clear: assert property (@(posedge clk_sys) disable iff (reset)
    cmd.int_clear && next_state == sensor_state_reg |=> int_n)
    else $error("interrupt pin not released by clear");
  chk_fetch_data: assert property (@(posedge clk_sys) disable iff (reset)
    fetch && xact.rd_req && !xact.start && !cmd.reinit |=> rd_data == $past(sensor_state_reg))
    else $error("fetch did not return sensor state");
  chk_sample_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_SAMPLE && filt[8] && !asleep && !cmd.reinit |=> up_pulse != 8'h00 && down_pulse == 8'h00)
    else $error("reference first without up pulse");
endmodule
`default_nettype wire

// ==== logic/touch_pkg.sv ====
// Shared opcodes, defaults, timing counts and carrier types of the touch sense core
`default_nettype none
package touch_pkg;
  localparam logic [7:0] OP_REINIT    = 8'h00;
  localparam logic [7:0] OP_INT_CLEAR = 8'h03;
  localparam logic [7:0] OP_SLEEP     = 8'h05;
  localparam logic [7:0] OP_WAKE      = 8'h06;
  localparam logic [7:0] OP_WR_CONFIG = 8'h30;
  localparam logic [7:0] OP_RD_CONFIG = 8'h33;
  localparam logic [7:0] OP_WR_CLOCK  = 8'h35;
  localparam logic [7:0] OP_RD_CLOCK  = 8'h36;
  localparam logic [7:0] OP_WR_MASK   = 8'h39;
  localparam logic [7:0] OP_RD_MASK   = 8'h3A;
  localparam logic [7:0] OP_BUS_INT   = 8'h3C;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CLOCK_RESET  = 8'h0C;
  localparam logic [7:0] MASK_RESET   = 8'hFF;
  localparam logic [7:0] STATE_RESET  = 8'h00;

  localparam int CHANNELS     = 8;
  localparam int RUN_W        = 7;
  localparam logic [6:0] DETECT_RUN  = 7'h40;
  localparam logic [6:0] RELEASE_RUN = 7'h40;

  // Cascade role field of the configuration byte
  localparam int OPM_LSB = 6;
  localparam logic [1:0] OPM_SECONDARY = 2'h1;
  localparam logic [1:0] OPM_PRIMARY   = 2'h2;

  localparam int CLK_PERIOD_PS     = 8000;
  localparam int FAST_START_NS     = 2000;
  localparam int SAMPLE_WINDOW_NS  = 4000;
  localparam int FAST_START_CYCLES = (FAST_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SAMPLE_CYCLES     = (SAMPLE_WINDOW_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] GAP_BASE  = 8'h10;

  typedef struct packed {
    logic       start;
    logic       rw;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       rd_req;
  } bus_xact_s;

  typedef struct packed {
    logic       reinit;
    logic       int_clear;
    logic       sleep;
    logic       wake;
    logic       bus_int;
    logic       wr_config;
    logic       wr_clock;
    logic       wr_mask;
    logic [7:0] data;
  } cmd_s;

  typedef enum logic [1:0] {
    RD_STATE  = 2'h0,
    RD_CONFIG = 2'h1,
    RD_CLOCK  = 2'h2,
    RD_MASK   = 2'h3
  } rd_sel_e;
endpackage
`default_nettype wire

// ==== sim/bus_master_model.sv ====
// System controller and analog comparator model facing the touch core
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic                 clk_sys,
  input  wire logic                 ref_trigger,
  input  wire logic [7:0]           chan_sel,
  input  wire logic [7:0]           touch,
  output var  logic                 ref_tripped,
  output var  logic [7:0]           chan_tripped,
  output var  touch_pkg::bus_xact_s xact
);
  logic [7:0] exp_q[$];
  logic [7:0] win;
  initial xact = '0;
  always @(posedge clk_sys)
  begin
    win <= ref_trigger ? win + 8'h01 : 8'h00;
  end
  // A touched plate discharges slower, so the reference wins only there
  assign ref_tripped  = ref_trigger & (win >= 8'h06);
  assign chan_tripped = chan_sel & ((touch & {8{win >= 8'h0A}}) | (~touch & {8{win >= 8'h02}}));
  // One-cycle strobe, then a quiet cycle before the next one
  task automatic pulse(input touch_pkg::bus_xact_s v);
    @(negedge clk_sys);
    xact = v;
    @(negedge clk_sys);
    xact = '0;
  endtask
  task automatic open_xact(input logic rw);
    touch_pkg::bus_xact_s v;
    v = '0;
    v.start = 1'b1;
    v.rw = rw;
    pulse(v);
  endtask
  task automatic put(input logic [7:0] b);
    touch_pkg::bus_xact_s v;
    v = '0;
    v.wr_valid = 1'b1;
    v.wr_byte = b;
    pulse(v);
  endtask
  task automatic get(input logic [7:0] expected);
    touch_pkg::bus_xact_s v;
    v = '0;
    v.rd_req = 1'b1;
    exp_q.push_back(expected);
    pulse(v);
  endtask
  task automatic cmd(input logic [7:0] op);
    open_xact(1'b0);
    put(op);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(op);
    put(d);
  endtask
endmodule
`default_nettype wire

// ==== sim/touch_sense_command_control_tb.sv ====
// Self-checking testbench of the touch core
`timescale 1ns/1ps
`default_nettype none
module touch_sense_command_control_tb;
  logic                 clk_sys;
  logic                 reset;
  logic                 sleep_pin;
  logic [7:0]           touch;
  logic                 ref_tripped;
  logic [7:0]           chan_tripped;
  touch_pkg::bus_xact_s xact;
  logic [7:0]           rd_data;
  logic                 int_n;
  logic                 bus_int_mode;
  logic                 ref_trigger;
  logic [7:0]           chan_sel;
  logic [7:0]           up_pulse;
  logic [7:0]           down_pulse;
  logic                 analog_en;
  logic                 fast_start;
  logic [7:0]           config_reg;
  logic [7:0]           clock_setting_reg;
  logic [7:0]           mask_reg;
  logic [7:0]           sensor_state_reg;
  logic                 rd_own;
  logic                 rd_seen;
  logic [7:0]           d;
  logic [7:0]           wr_ops[3];
  logic [7:0]           rd_ops[3];
  int                   n_fail;
  int                   compares;

  touch_core i_touch_core (.clk_sys(clk_sys), .reset(reset), .sleep_pin(sleep_pin),
    .ref_tripped(ref_tripped), .chan_tripped(chan_tripped), .xact(xact), .rd_data(rd_data), .rd_own(rd_own),
    .int_n(int_n), .bus_int_mode(bus_int_mode), .ref_trigger(ref_trigger), .chan_sel(chan_sel),
    .up_pulse(up_pulse), .down_pulse(down_pulse), .analog_en(analog_en), .fast_start(fast_start),
    .config_reg(config_reg), .clock_setting_reg(clock_setting_reg), .mask_reg(mask_reg),
    .sensor_state_reg(sensor_state_reg));
  bus_master_model i_bus_master_model (.clk_sys(clk_sys), .ref_trigger(ref_trigger), .chan_sel(chan_sel),
    .touch(touch), .ref_tripped(ref_tripped), .chan_tripped(chan_tripped), .xact(xact));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic set_pin(input logic v);
    sleep_pin = v;
    idle(8);
  endtask
  task automatic check_defaults;
    check(config_reg, touch_pkg::CONFIG_RESET, "config");
    check(clock_setting_reg, touch_pkg::CLOCK_RESET, "clock");
    check(mask_reg, touch_pkg::MASK_RESET, "mask");
    check(sensor_state_reg, touch_pkg::STATE_RESET, "state");
    check({7'h00, bus_int_mode}, 8'h00, "bus int mode");
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // The read byte is settled on the same edge that takes its request, checked at the next falling edge
  always @(posedge clk_sys)
  begin
    rd_seen <= xact.rd_req;
  end
  always @(negedge clk_sys)
  begin
    if (rd_seen === 1'b1)
      check(rd_data, i_bus_master_model.exp_q.pop_front(), "read byte");
    if (|up_pulse)
      check(up_pulse & ~touch, 8'h00, "up pulse");
    if (|down_pulse)
      check(down_pulse & touch, 8'h00, "down pulse");
    // One channel selected exactly while the reference runs
    if (reset === 1'b0)
      check({7'h00, ref_trigger ^ (|chan_sel)} | (chan_sel & (chan_sel - 8'h01)), 8'h00, "channel select");
  end

  initial
  begin
    reset = 1'b1;
    sleep_pin = 1'b0;
    touch = 8'h00;
    n_fail = 0;
    compares = 0;
    wr_ops = '{touch_pkg::OP_WR_CONFIG, touch_pkg::OP_WR_CLOCK, touch_pkg::OP_WR_MASK};
    rd_ops = '{touch_pkg::OP_RD_CONFIG, touch_pkg::OP_RD_CLOCK, touch_pkg::OP_RD_MASK};
    void'($urandom(35928));
    idle(4);
    reset = 1'b0;
    idle(1);
    check_defaults();
    check({7'h00, int_n}, 8'h01, "int idle");
    $display("test reset values done");

    touch = 8'($urandom()) | 8'h01;
    for (int i = 0; i < 50000 && sensor_state_reg !== touch; i++)
      idle(1);
    idle(4);
    check(sensor_state_reg, touch, "detected state");
    check({7'h00, int_n}, 8'h00, "int raised");
    // Primary role: this chip owns the first read byte, then turns alternate
    i_bus_master_model.wr(touch_pkg::OP_WR_CONFIG, 8'h80);
    i_bus_master_model.open_xact(1'b1);
    check({7'h00, rd_own}, 8'h01, "own first byte");
    i_bus_master_model.get(touch);
    check({7'h00, rd_own}, 8'h00, "own second byte");
    i_bus_master_model.get(touch);
    check({7'h00, rd_own}, 8'h01, "own third byte");
    idle(3);
    check({7'h00, int_n}, 8'h01, "int after fetch");
    i_bus_master_model.wr(touch_pkg::OP_WR_MASK, 8'h00);
    idle(3);
    check({7'h00, int_n}, 8'h00, "int on mask change");
    i_bus_master_model.cmd(touch_pkg::OP_INT_CLEAR);
    idle(3);
    check({7'h00, int_n}, 8'h01, "int cleared");
    $display("test detect and fetch done");

    for (int k = 0; k < 3; k++)
    begin
      d = 8'($urandom());
      i_bus_master_model.wr(wr_ops[k], d);
      i_bus_master_model.cmd(rd_ops[k]);
      i_bus_master_model.get(d);
    end
    idle(3);
    d = clock_setting_reg;
    i_bus_master_model.open_xact(1'b1);
    i_bus_master_model.put(touch_pkg::OP_WR_CLOCK);
    i_bus_master_model.put(~d);
    i_bus_master_model.cmd(8'h01);
    i_bus_master_model.put(~d);
    idle(3);
    check(clock_setting_reg, d, "clock kept");
    $display("test registers done");

    i_bus_master_model.cmd(touch_pkg::OP_SLEEP);
    idle(4);
    check({7'h00, analog_en}, 8'h00, "command sleep");
    i_bus_master_model.cmd(touch_pkg::OP_RD_CLOCK);
    i_bus_master_model.get(d);
    set_pin(1'b1);
    set_pin(1'b0);
    check({7'h00, analog_en}, 8'h00, "pin cannot wake");
    i_bus_master_model.cmd(touch_pkg::OP_WAKE);
    idle(4);
    check({6'h00, analog_en, fast_start}, 8'h03, "woken");
    set_pin(1'b1);
    check({7'h00, analog_en}, 8'h00, "pin sleep");
    i_bus_master_model.cmd(touch_pkg::OP_WAKE);
    idle(4);
    check({7'h00, analog_en}, 8'h00, "wake cannot end pin sleep");
    set_pin(1'b0);
    check({7'h00, analog_en}, 8'h01, "pin low wakes");
    $display("test sleep done");

    i_bus_master_model.cmd(touch_pkg::OP_BUS_INT);
    idle(3);
    check({7'h00, bus_int_mode}, 8'h01, "bus int mode");
    i_bus_master_model.cmd(touch_pkg::OP_REINIT);
    idle(3);
    check_defaults();
    $display("test reinit done");
    end_sim();
  end
endmodule
`default_nettype wire
